// file: hw/lepc_map.vh
// Purpose: Constants for the legacy emulation palette and configuration block.
// Assumes: Plain Verilog-2005 includer.
// Notes:   Port numbers are CPU I/O addresses.
`ifndef LEPC_MAP_VH
`define LEPC_MAP_VH

`define LEPC_IO_CFG        16'h03bf
`define LEPC_IO_PAL        16'h03d9
`define LEPC_IO_SEQ_IDX    16'h03c4
`define LEPC_REG_RESET     8'h00
`define LEPC_BYTE_ZERO     8'h00
`define LEPC_COL_BLANK     4'h0
`define LEPC_SEQ_KEEP_MSB  5

`define LEPC_EMU_COLOUR_BIT 0
`define LEPC_EMU_ACT_BIT   2
`define LEPC_EMU_EN_BIT    3
`define LEPC_MISC_MAP_BIT  0
`define LEPC_MODE_PAGE_BIT 7

`define LEPC_PAL_IRGB_MSB  3
`define LEPC_PAL_IRGB_LSB  0
`define LEPC_PAL_ALT_BIT   4
`define LEPC_PAL_SET_BIT   5
`define LEPC_CFG_GFX_BIT   0
`define LEPC_CFG_PAGE_BIT  1

`define LEPC_SEG_LOW       20'hb0000
`define LEPC_SEG_TEXT_END  20'hb0fff
`define LEPC_SEG_HALF_END  20'hb7fff
`define LEPC_SEG_UP        20'hb8000
`define LEPC_SEG_FULL_END  20'hbffff

// Four-bit IRGB codes for the 320x200 colour sets.
`define LEPC_COL_GREEN     4'h2
`define LEPC_COL_RED       4'h4
`define LEPC_COL_BROWN     4'h6
`define LEPC_COL_CYAN      4'h3
`define LEPC_COL_MAGENTA   4'h5
`define LEPC_COL_WHITE     4'h7

`endif

// file: hw/lepc_colour_map.v
// Purpose: Maps a 320x200 two-bit pixel code to an IRGB colour.
// Assumes: Palette register contents supplied by the parent.
// Notes:   Registered output, one cycle of latency.
`include "lepc_map.vh"

module lepc_colour_map (
    input  wire       clk,
    input  wire       rst_b,
    input  wire [7:0] palette,
    input  wire [1:0] pixel_code,
    output reg  [3:0] pixel_irgb
);

    reg [3:0] next_pixel_irgb;

    always @* begin
        next_pixel_irgb = palette[`LEPC_PAL_IRGB_MSB:`LEPC_PAL_IRGB_LSB];
        if (pixel_code != 2'b00) begin
            if (palette[`LEPC_PAL_SET_BIT]) begin
                if (pixel_code == 2'b01)
                    next_pixel_irgb = `LEPC_COL_CYAN;
                else if (pixel_code == 2'b10)
                    next_pixel_irgb = `LEPC_COL_MAGENTA;
                else
                    next_pixel_irgb = `LEPC_COL_WHITE;
            end else begin
                if (pixel_code == 2'b01)
                    next_pixel_irgb = `LEPC_COL_GREEN;
                else if (pixel_code == 2'b10)
                    next_pixel_irgb = `LEPC_COL_RED;
                else
                    next_pixel_irgb = `LEPC_COL_BROWN;
            end
            // The alternate set lifts the three foreground colours to intensity.
            next_pixel_irgb[3] = palette[`LEPC_PAL_ALT_BIT];
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            pixel_irgb <= `LEPC_COL_BLANK;
        else
            pixel_irgb <= next_pixel_irgb;
    end

endmodule

// file: hw/lepc_regs.v
// Purpose: Palette select and monochrome-graphics configuration registers.
// Assumes: CPU I/O strobes are one-cycle pulses synchronous to clk.
// Notes:   Colour outputs and memory window checks follow the emulation state.
`include "lepc_map.vh"

module lepc_regs (
    input  wire        clk,
    input  wire        rst_b,
    input  wire [15:0] io_addr,
    input  wire        io_wr,
    input  wire        io_rd,
    input  wire [7:0]  io_wdata,
    output reg  [7:0]  io_rdata,
    output reg         io_hit,
    input  wire [7:0]  seq_index,
    input  wire [7:0]  emulation_mode_register,
    input  wire [7:0]  misc_output,
    input  wire [7:0]  mode_control,
    input  wire        mode_text_40,
    input  wire        mode_gfx_320,
    input  wire        mode_gfx_640,
    input  wire [1:0]  pixel_code,
    input  wire [19:0] cpu_mem_addr,
    output reg  [3:0]  border_irgb,
    output reg  [3:0]  background_irgb,
    output reg  [3:0]  foreground_irgb,
    output reg         text_bg_select,
    output wire [3:0]  pixel_irgb,
    output reg         palette_active,
    output reg         config_active,
    output reg         graphics_enabled,
    output reg         page_select,
    output reg  [19:0] page_base,
    output reg         cpu_mem_allowed
);

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    reg  [7:0]  colour_adapter_palette_select;
    reg  [7:0]  mono_graphics_configuration;
    reg  [7:0]  next_palette_select;
    reg  [7:0]  next_configuration;
    wire        sel_pal;
    wire        sel_cfg;
    wire        sel_seq;
    wire        colour_emu;
    wire        emu_on;
    wire        pal_on;
    wire        cfg_on;
    wire        cfg_gfx;
    wire        cfg_page;
    wire        page_grant;
    wire        mode_text;
    wire [3:0]  pal_irgb;
    wire [7:0]  pal_to_map;
    reg  [7:0]  next_rdata;
    reg         next_hit;
    reg  [3:0]  next_border;
    reg  [3:0]  next_background;
    reg  [3:0]  next_foreground;
    reg         next_text_bg;
    reg  [19:0] next_limit;
    reg  [19:0] next_page_base;
    reg         next_mem_allowed;

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // Gates the palette colour onto one display-mode output.
    function [3:0] lepc_mode_colour;
        input       gate;
        input [3:0] colour;
        begin
            if (gate)
                lepc_mode_colour = colour;
            else
                lepc_mode_colour = `LEPC_COL_BLANK;
        end
    endfunction

    // True when an I/O address names the given port.
    function lepc_port_match;
        input [15:0] addr;
        input [15:0] port;
        begin
            lepc_port_match = (addr == port);
        end
    endfunction

    // Sequencer index readback with the two configuration bits on top.
    function [7:0] lepc_seq_readback;
        input [7:0] cfg;
        input [7:0] idx;
        begin
            lepc_seq_readback = {cfg[`LEPC_CFG_PAGE_BIT], cfg[`LEPC_CFG_GFX_BIT],
                                 idx[`LEPC_SEQ_KEEP_MSB:0]};
        end
    endfunction

    // Upper end of the CPU window for the current configuration.
    function [19:0] lepc_window_limit;
        input gfx;
        input page;
        begin
            if (!gfx)
                lepc_window_limit = `LEPC_SEG_TEXT_END;
            else if (!page)
                lepc_window_limit = `LEPC_SEG_HALF_END;
            else
                lepc_window_limit = `LEPC_SEG_FULL_END;
        end
    endfunction

    // True when a CPU address lies between the window base and the limit.
    function lepc_in_window;
        input [19:0] addr;
        input [19:0] limit;
        begin
            lepc_in_window = (addr >= `LEPC_SEG_LOW) && (addr <= limit);
        end
    endfunction

    // ------------------------------------------------------------
    // Port and emulation decode
    // ------------------------------------------------------------
    assign sel_pal    = lepc_port_match(io_addr, `LEPC_IO_PAL);
    assign sel_cfg    = lepc_port_match(io_addr, `LEPC_IO_CFG);
    assign sel_seq    = lepc_port_match(io_addr, `LEPC_IO_SEQ_IDX);
    assign colour_emu = emulation_mode_register[`LEPC_EMU_COLOUR_BIT];
    assign emu_on     = emulation_mode_register[`LEPC_EMU_ACT_BIT];
    assign pal_on     = emu_on & emulation_mode_register[`LEPC_EMU_EN_BIT];
    assign cfg_on     = emu_on & ~misc_output[`LEPC_MISC_MAP_BIT];
    // With the configuration inactive the register imposes no limits.
    assign cfg_gfx    = ~cfg_on | mono_graphics_configuration[`LEPC_CFG_GFX_BIT];
    assign cfg_page   = ~cfg_on | mono_graphics_configuration[`LEPC_CFG_PAGE_BIT];
    // The page request only counts while the upper page is allowed.
    assign page_grant = cfg_page & mode_control[`LEPC_MODE_PAGE_BIT];
    assign mode_text  = ~mode_gfx_320 & ~mode_gfx_640;
    assign pal_irgb   = colour_adapter_palette_select[`LEPC_PAL_IRGB_MSB:`LEPC_PAL_IRGB_LSB];
    // The colour map sees a blank palette while the palette is disabled.
    assign pal_to_map = pal_on ? colour_adapter_palette_select : `LEPC_BYTE_ZERO;

    // ------------------------------------------------------------
    // Register write path
    // ------------------------------------------------------------
    // A palette write outside colour-adapter emulation is dropped silently.
    always @* begin
        next_palette_select = colour_adapter_palette_select;
        if (io_wr && sel_pal && colour_emu)
            next_palette_select = io_wdata;
    end

    always @* begin
        next_configuration = mono_graphics_configuration;
        if (io_wr && sel_cfg)
            next_configuration = io_wdata;
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            colour_adapter_palette_select <= `LEPC_REG_RESET;
        else
            colour_adapter_palette_select <= next_palette_select;
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            mono_graphics_configuration <= `LEPC_REG_RESET;
        else
            mono_graphics_configuration <= next_configuration;
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always @* begin
        next_rdata = `LEPC_BYTE_ZERO;
        next_hit   = 1'b0;
        if (sel_pal) begin
            next_rdata = colour_adapter_palette_select;
            next_hit   = 1'b1;
        end else if (sel_cfg) begin
            next_rdata = mono_graphics_configuration;
            next_hit   = 1'b1;
        end else if (sel_seq) begin
            next_rdata = lepc_seq_readback(mono_graphics_configuration, seq_index);
            next_hit   = 1'b1;
        end
    end

    // Read data holds until the next read.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            io_rdata <= `LEPC_BYTE_ZERO;
        else if (io_rd)
            io_rdata <= next_rdata;
    end

    // The hit flag lasts one cycle after each read of a mapped port.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            io_hit <= 1'b0;
        else
            io_hit <= io_rd & next_hit;
    end

    // ------------------------------------------------------------
    // Palette colour outputs
    // ------------------------------------------------------------
    always @* begin
        next_border     = lepc_mode_colour(pal_on && mode_text_40, pal_irgb);
        next_background = lepc_mode_colour(pal_on && mode_gfx_320, pal_irgb);
        next_foreground = lepc_mode_colour(pal_on && mode_gfx_640, pal_irgb);
        // Bit 4 picks background colours only while a text mode is shown.
        next_text_bg    = pal_on & mode_text &
                          colour_adapter_palette_select[`LEPC_PAL_ALT_BIT];
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            border_irgb     <= `LEPC_COL_BLANK;
            background_irgb <= `LEPC_COL_BLANK;
            foreground_irgb <= `LEPC_COL_BLANK;
            text_bg_select  <= 1'b0;
        end else begin
            border_irgb     <= next_border;
            background_irgb <= next_background;
            foreground_irgb <= next_foreground;
            text_bg_select  <= next_text_bg;
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            palette_active <= 1'b0;
        else
            palette_active <= pal_on;
    end

    lepc_colour_map u_colour_map (
        .clk        (clk),
        .rst_b      (rst_b),
        .palette    (pal_to_map),
        .pixel_code (pixel_code),
        .pixel_irgb (pixel_irgb)
    );

    // ------------------------------------------------------------
    // Memory window and page control
    // ------------------------------------------------------------
    always @* begin
        next_limit = lepc_window_limit(cfg_gfx, cfg_page);
        if (page_grant)
            next_page_base = `LEPC_SEG_UP;
        else
            next_page_base = `LEPC_SEG_LOW;
        next_mem_allowed = lepc_in_window(cpu_mem_addr, next_limit);
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            config_active    <= 1'b0;
            graphics_enabled <= 1'b0;
        end else begin
            config_active    <= cfg_on;
            graphics_enabled <= cfg_gfx;
        end
    end

    // The base moves in the same cycle as the page flag, so the two never disagree.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            page_select <= 1'b0;
            page_base   <= `LEPC_SEG_LOW;
        end else begin
            page_select <= page_grant;
            page_base   <= next_page_base;
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            cpu_mem_allowed <= 1'b0;
        else
            cpu_mem_allowed <= next_mem_allowed;
    end

endmodule

// file: test/lepc_regs_assertions.sv
// Purpose: Port checks for the palette and configuration registers.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Attached by bind from the testbench.
module lepc_regs_assertions (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic [15:0] io_addr,
    input wire logic        io_rd,
    input wire logic [7:0]  io_rdata,
    input wire logic        io_hit,
    input wire logic [7:0]  emulation_mode_register,
    input wire logic [7:0]  misc_output,
    input wire logic [7:0]  mode_control,
    input wire logic [19:0] cpu_mem_addr,
    input wire logic        palette_active,
    input wire logic        config_active,
    input wire logic        page_select,
    input wire logic [19:0] page_base,
    input wire logic        cpu_mem_allowed
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    AST_HIT: assert property (io_rd && io_addr == 16'h03bf |=> io_hit)
        else $error("mapped read gave no hit");
    AST_UNMAP: assert property (io_rd && !(io_addr inside {16'h03bf, 16'h03d9, 16'h03c4})
        |=> !io_hit && io_rdata == 8'h00) else $error("unmapped read answered");
    AST_NO_HIT: assert property (!io_rd |=> !io_hit)
        else $error("hit without read");
    AST_PAL_OFF: assert property (!(emulation_mode_register[2] && emulation_mode_register[3])
        |=> !palette_active) else $error("palette active while disabled");
    AST_PAL_ON: assert property (emulation_mode_register[2] && emulation_mode_register[3]
        |=> palette_active) else $error("palette not active");
    AST_CFG_ON: assert property (emulation_mode_register[2] && !misc_output[0]
        |=> config_active) else $error("configuration not active");
    AST_PAGE_BASE: assert property (page_base == (page_select ? 20'hb8000 : 20'hb0000))
        else $error("page base does not follow page select");
    AST_PAGE_REQ: assert property (page_select |-> $past(mode_control[7]))
        else $error("page set without request");
    AST_MEM_LOW: assert property (cpu_mem_addr < 20'hb0000 |=> !cpu_mem_allowed)
        else $error("access below window allowed");
endmodule

// file: test/testbench.sv
// Purpose: Self-checking bench for the palette and configuration registers.
// Assumes: Strobes driven 1 ns after the rising edge.
// Notes:   Read data is checked 1 ns after the edge that takes the read strobe.
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0, rst_b = 1'b0, io_wr = 1'b0, io_rd = 1'b0;
    logic [15:0] io_addr = 16'h0000;
    logic [7:0]  io_wdata = 8'h00, seq_index = 8'h2a, emu = 8'h00, misc = 8'h00, mode = 8'h00;
    logic [2:0]  mode_sel = 3'b000;
    logic [1:0]  pixel_code = 2'b00;
    logic [19:0] cpu_mem_addr = 20'h00000, page_base;
    logic [7:0]  io_rdata;
    logic [3:0]  border_irgb, background_irgb, foreground_irgb, pixel_irgb;
    logic        io_hit, text_bg_select, palette_active, config_active;
    logic        graphics_enabled, page_select, cpu_mem_allowed;
    logic [3:0]  ctab [8] = '{4'h9, 4'h2, 4'h4, 4'h6, 4'h9, 4'h3, 4'h5, 4'h7};
    int          err_count = 0, compares = 0;
    always #10 clk = ~clk;
    lepc_regs uut (.clk(clk), .rst_b(rst_b), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .io_hit(io_hit), .seq_index(seq_index),
        .emulation_mode_register(emu), .misc_output(misc), .mode_control(mode),
        .mode_text_40(mode_sel[0]), .mode_gfx_320(mode_sel[1]), .mode_gfx_640(mode_sel[2]),
        .pixel_code(pixel_code), .cpu_mem_addr(cpu_mem_addr), .border_irgb(border_irgb),
        .background_irgb(background_irgb), .foreground_irgb(foreground_irgb),
        .text_bg_select(text_bg_select), .pixel_irgb(pixel_irgb),
        .palette_active(palette_active), .config_active(config_active),
        .graphics_enabled(graphics_enabled), .page_select(page_select),
        .page_base(page_base), .cpu_mem_allowed(cpu_mem_allowed));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic wrap_up;
        $display("Mismatches %0d in %0d comparisons", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        cyc(1);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        cyc(1);
        io_wr = 1'b0;
    endtask
    task automatic rdc(input logic [15:0] a, input logic [7:0] e, input logic h);
        cyc(1);
        io_addr = a;
        io_rd = 1'b1;
        cyc(1);
        io_rd = 1'b0;
        chk({io_hit, io_rdata}, {h, e});
    endtask
    task automatic mem(input logic [19:0] a, input logic e);
        cpu_mem_addr = a;
        cyc(2);
        chk(cpu_mem_allowed, e);
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        wrap_up;
    end
    initial begin
        cyc(5);
        rst_b = 1'b1;
        chk(page_base, 20'hb0000);
        rdc(16'h03d9, 8'h00, 1'b1);
        rdc(16'h03c0, 8'h00, 1'b0);
        wr(16'h03d9, 8'h15);
        rdc(16'h03d9, 8'h00, 1'b1);
        emu = 8'h0d;
        wr(16'h03d9, 8'h1b);
        rdc(16'h03d9, 8'h1b, 1'b1);
        for (int m = 0; m < 3; m++) begin
            mode_sel = 3'b001 << m;
            cyc(2);
            chk({border_irgb, background_irgb, foreground_irgb}, 12'hb00 >> (4 * m));
        end
        mode_sel = 3'b001;
        cyc(2);
        chk(text_bg_select, 1'b1);
        emu = 8'h05;
        cyc(2);
        chk({palette_active, border_irgb}, 5'h00);
        emu = 8'h09;
        cyc(2);
        chk({palette_active, border_irgb}, 5'h00);
        emu = 8'h0d;
        mode_sel = 3'b010;
        for (int s = 0; s < 2; s++) begin
            wr(16'h03d9, {2'b00, s[0], 5'h09});
            for (int c = 0; c < 4; c++) begin
                pixel_code = c[1:0];
                cyc(3);
                chk(pixel_irgb, ctab[s * 4 + c]);
            end
        end
        wr(16'h03d9, 8'h39);
        pixel_code = 2'b01;
        cyc(3);
        chk(pixel_irgb, 4'hb);
        emu = 8'h05;
        wr(16'h03bf, 8'h03);
        rdc(16'h03c4, 8'hea, 1'b1);
        rdc(16'h03bf, 8'h03, 1'b1);
        mode = 8'h80;
        cyc(2);
        chk({page_select, page_base}, 21'h1b8000);
        mem(20'hbc000, 1'b1);
        wr(16'h03bf, 8'h01);
        mem(20'hb8000, 1'b0);
        mem(20'hb7fff, 1'b1);
        chk({page_select, page_base}, 21'h0b0000);
        wr(16'h03bf, 8'h00);
        mem(20'hb1000, 1'b0);
        mem(20'hb0fff, 1'b1);
        chk(graphics_enabled, 1'b0);
        misc = 8'h01;
        mem(20'hbffff, 1'b1);
        chk(config_active, 1'b0);
        mem(20'haffff, 1'b0);
        wrap_up;
    end
endmodule
bind lepc_regs lepc_regs_assertions u_chk (.clk(clk), .rst_b(rst_b), .io_addr(io_addr),
    .io_rd(io_rd), .io_rdata(io_rdata), .io_hit(io_hit),
    .emulation_mode_register(emulation_mode_register), .misc_output(misc_output),
    .mode_control(mode_control), .cpu_mem_addr(cpu_mem_addr), .palette_active(palette_active),
    .config_active(config_active), .page_select(page_select), .page_base(page_base),
    .cpu_mem_allowed(cpu_mem_allowed));
